// *** design/fsap_defines.vh ***
`ifndef FSAP_DEFINES_VH
`define FSAP_DEFINES_VH

// ****************************************
// array geometry
// ****************************************
`define FSAP_ADDR_W         16
`define FSAP_SECTOR_SIZE    17'h01000
`define FSAP_SEC0_BASE      16'hF000
`define FSAP_SEC1_BASE      16'hE000
`define FSAP_SIZE_4K        17'h01000
`define FSAP_SIZE_8K        17'h02000
`define FSAP_ERASED_BYTE    8'hFF

// ****************************************
// programming modes
// ****************************************
`define FSAP_MODE_W         2
`define FSAP_MODE_APP       2'h0
`define FSAP_MODE_TOOL      2'h1
`define FSAP_MODE_CIRCUIT   2'h2
`define FSAP_MODE_INAPP     2'h3

// ****************************************
// operations
// ****************************************
`define FSAP_OP_W           2
`define FSAP_OP_PROG        2'h0
`define FSAP_OP_SEC_ERASE   2'h1
`define FSAP_OP_MASS_ERASE  2'h2
`define FSAP_OP_OPT_PROG    2'h3

// ****************************************
// option byte
// ****************************************
`define FSAP_OPT_RESET      8'h00
`define FSAP_OPT_RDP_BIT    0

// ****************************************
// results
// ****************************************
`define FSAP_RES_W          2
`define FSAP_RES_OK         2'h0
`define FSAP_RES_PROTECTED  2'h1
`define FSAP_RES_RANGE      2'h2

`endif

// *** design/fsap_sync.v ***
`timescale 1ns/10ps
// three-stage sampler; a change counts when stages two and three agree
module fsap_sync (
    input  wire ref_clk,
    input  wire arst_n,
    input  wire din,
    output reg  dout
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // fsap_sync

// *** design/fsap_sector_decode.v ***
`timescale 1ns/10ps
`include "fsap_defines.vh"
// maps an address to a sector number, flags addresses outside the array
module fsap_sector_decode #(
    parameter ARRAY_BYTES = 17'h0F000
) (
    input  wire [15:0] addr,
    output reg  [1:0]  sector,
    output reg         in_array
);
    wire [16:0] base = 17'h10000 - ARRAY_BYTES;

    always @* begin
        sector   = 2'h2;
        in_array = ({1'b0, addr} >= base);
        if (addr >= `FSAP_SEC0_BASE) begin
            sector = 2'h0;
        end else if (addr >= `FSAP_SEC1_BASE) begin
            sector = 2'h1;
        end
        if (ARRAY_BYTES <= `FSAP_SIZE_4K && sector != 2'h0) begin
            in_array = 1'b0;
        end else if (ARRAY_BYTES <= `FSAP_SIZE_8K && sector == 2'h2) begin
            in_array = 1'b0;
        end
    end
endmodule // fsap_sector_decode

// *** design/fsap_access.v ***
`timescale 1ns/10ps
`include "fsap_defines.vh"

// ****************************************
// flash sector access and protection
// ****************************************
module fsap_access #(
    parameter ARRAY_BYTES = 17'h0F000
) (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        tool_socket,
    input  wire        tool_attached,
    input  wire        programming_voltage_select,
    input  wire        incirc_serial_clock,
    input  wire        incirc_serial_data_in,
    output reg         incirc_serial_data_out,
    output reg         incirc_serial_data_oe,
    input  wire        link_data_out,
    input  wire        link_data_oe,
    output reg         link_clock_rise,
    output reg         link_data,
    input  wire        app_pin_out,
    input  wire        app_pin_oe,
    output reg         app_pin_in,
    input  wire        iap_enter,
    input  wire        fetch_from_sector0,
    input  wire        req_valid,
    input  wire [1:0]  req_op,
    input  wire [15:0] req_addr,
    input  wire [7:0]  req_data,
    input  wire        req_external,
    output reg         busy,
    output reg         done,
    output reg  [1:0]  result,
    output reg  [7:0]  rd_data,
    output reg  [7:0]  option_byte,
    output reg         readout_protect_option,
    output reg         low_voltage_detector_en,
    output reg  [1:0]  mode
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_WIPE  = 2'h1;
    localparam ST_DONE  = 2'h2;
    localparam DEPTH    = 65536;
    localparam [16:0] ARRAY_SIZE = ARRAY_BYTES[16:0];

    // ****************************************
    // storage
    // ****************************************
    // full 64K byte space as flops; synthesis keeps only the mapped part
    reg  [7:0]  mem [0:DEPTH-1];
    reg  [1:0]  state;
    reg  [16:0] wipe_ptr;
    reg  [1:0]  wipe_sector;
    reg         wipe_all;
    reg  [7:0]  pend_opt;
    // set only when a protection removal owns the wipe
    reg         wipe_opt;

    wire        s_clk;
    wire        s_data;
    wire        s_vpp;
    wire        s_tool;
    wire        s_sock;
    reg         clk_prev;
    wire [1:0]  req_sector;
    wire        req_in_array;
    wire [1:0]  wp_sector;
    wire        wp_in;
    reg         allowed;
    reg  [1:0]  next_mode;
    wire [16:0] base = 17'h10000 - ARRAY_SIZE;

    fsap_sync u_sclk (.ref_clk(ref_clk), .arst_n(arst_n), .din(incirc_serial_clock),
                      .dout(s_clk));
    fsap_sync u_sdat (.ref_clk(ref_clk), .arst_n(arst_n), .din(incirc_serial_data_in),
                      .dout(s_data));
    fsap_sync u_svpp (.ref_clk(ref_clk), .arst_n(arst_n), .din(programming_voltage_select),
                      .dout(s_vpp));
    fsap_sync u_stool (.ref_clk(ref_clk), .arst_n(arst_n), .din(tool_attached),
                       .dout(s_tool));
    fsap_sync u_ssock (.ref_clk(ref_clk), .arst_n(arst_n), .din(tool_socket),
                       .dout(s_sock));

    fsap_sector_decode #(.ARRAY_BYTES(ARRAY_BYTES)) u_dec (
        .addr     (req_addr),
        .sector   (req_sector),
        .in_array (req_in_array)
    );
    fsap_sector_decode #(.ARRAY_BYTES(ARRAY_BYTES)) u_wdec (
        .addr     (wipe_ptr[15:0]),
        .sector   (wp_sector),
        .in_array (wp_in)
    );

    // ****************************************
    // protection state
    // ****************************************
    // option bit counts at once, so the flag's one-cycle lag opens no window
    wire        prot_now = readout_protect_option | option_byte[`FSAP_OPT_RDP_BIT];

    // ****************************************
    // mode selection
    // ****************************************
    always @* begin
        next_mode = `FSAP_MODE_APP;
        if (s_sock) begin
            next_mode = `FSAP_MODE_TOOL;
        end else if (s_tool && s_vpp) begin
            // tool has switched the part into the communication mode
            next_mode = `FSAP_MODE_CIRCUIT;
        end else if (iap_enter && fetch_from_sector0) begin
            // only a loader executing from sector 0 may open the window
            next_mode = `FSAP_MODE_INAPP;
        end
    end

    // ****************************************
    // permission check
    // ****************************************
    always @* begin
        allowed = 1'b1;
        // plain application mode never writes the array
        if (mode == `FSAP_MODE_APP) begin
            allowed = 1'b0;
        end
        if (mode == `FSAP_MODE_INAPP && req_op == `FSAP_OP_SEC_ERASE
            && req_sector == 2'h0) begin
            allowed = 1'b0;
        end
        if (mode == `FSAP_MODE_INAPP && req_op == `FSAP_OP_PROG && req_sector == 2'h0) begin
            allowed = 1'b0;
        end
        if (mode == `FSAP_MODE_INAPP && (req_op == `FSAP_OP_MASS_ERASE
            || req_op == `FSAP_OP_OPT_PROG)) begin
            allowed = 1'b0;
        end
        // protection blocks writes; option programming stays open to lift it, and mass erase stays open but leaves it set
        if (prot_now && req_op == `FSAP_OP_PROG) begin
            allowed = 1'b0;
        end
        if (prot_now && req_op == `FSAP_OP_SEC_ERASE) begin
            allowed = 1'b0;
        end
    end

    // ****************************************
    // pin ownership and link sampling
    // ****************************************
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_prev               <= 1'b0;
            link_clock_rise        <= 1'b0;
            link_data              <= 1'b0;
            incirc_serial_data_out <= 1'b0;
            incirc_serial_data_oe  <= 1'b0;
            app_pin_in             <= 1'b0;
        end else begin
            clk_prev        <= s_clk;
            link_clock_rise <= s_clk & ~clk_prev;
            link_data       <= s_data;
            if (s_tool) begin
                // pins belong to the link even between sessions
                incirc_serial_data_out <= link_data_out;
                incirc_serial_data_oe  <= link_data_oe;
                app_pin_in             <= 1'b0;
            end else begin
                // released pins go back to the application
                incirc_serial_data_out <= app_pin_out;
                incirc_serial_data_oe  <= app_pin_oe;
                app_pin_in             <= s_data;
            end
        end
    end

    // ****************************************
    // operation engine
    // ****************************************
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state                   <= ST_IDLE;
            mode                    <= `FSAP_MODE_APP;
            busy                    <= 1'b0;
            done                    <= 1'b0;
            result                  <= `FSAP_RES_OK;
            rd_data                 <= 8'h00;
            option_byte             <= `FSAP_OPT_RESET;
            readout_protect_option  <= 1'b0;
            low_voltage_detector_en <= 1'b1;
            wipe_ptr                <= 17'h00000;
            wipe_sector             <= 2'h0;
            wipe_all                <= 1'b0;
            pend_opt                <= `FSAP_OPT_RESET;
            wipe_opt                <= 1'b0;
        end else begin
            mode                    <= next_mode;
            done                    <= 1'b0;
            readout_protect_option  <= option_byte[`FSAP_OPT_RDP_BIT];
            low_voltage_detector_en <= ~option_byte[`FSAP_OPT_RDP_BIT];
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        if (!req_in_array && req_op != `FSAP_OP_OPT_PROG
                            && req_op != `FSAP_OP_MASS_ERASE) begin
                            result <= `FSAP_RES_RANGE;
                            done   <= 1'b1;
                        end else if (!allowed) begin
                            result <= `FSAP_RES_PROTECTED;
                            done   <= 1'b1;
                        end else begin
                            result <= `FSAP_RES_OK;
                            case (req_op)
                                `FSAP_OP_PROG: begin
                                    mem[req_addr] <= mem[req_addr] & req_data;
                                    done          <= 1'b1;
                                end
                                `FSAP_OP_SEC_ERASE: begin
                                    wipe_ptr    <= base;
                                    wipe_sector <= req_sector;
                                    wipe_all    <= 1'b0;
                                    wipe_opt    <= 1'b0;
                                    busy        <= 1'b1;
                                    state       <= ST_WIPE;
                                end
                                `FSAP_OP_MASS_ERASE: begin
                                    wipe_ptr <= base;
                                    wipe_all <= 1'b1;
                                    wipe_opt <= 1'b0;
                                    busy     <= 1'b1;
                                    state    <= ST_WIPE;
                                end
                                default: begin
                                    pend_opt <= req_data;
                                    if (prot_now
                                        && !req_data[`FSAP_OPT_RDP_BIT]) begin
                                        // removal only after the whole array is gone
                                        wipe_ptr <= base;
                                        wipe_all <= 1'b1;
                                        wipe_opt <= 1'b1;
                                        busy     <= 1'b1;
                                        state    <= ST_WIPE;
                                    end else begin
                                        option_byte <= req_data;
                                        done        <= 1'b1;
                                    end
                                end
                            endcase
                        end
                        if (req_op == `FSAP_OP_PROG && req_external) begin
                            rd_data <= 8'h00;
                        end
                    end else if (req_external && prot_now) begin
                        rd_data <= 8'h00;
                    end else begin
                        rd_data <= mem[req_addr];
                    end
                end
                ST_WIPE: begin
                    // one byte a cycle over the window; slow but needs no sector table
                    if (wp_in && (wipe_all || wp_sector == wipe_sector)) begin
                        mem[wipe_ptr[15:0]] <= `FSAP_ERASED_BYTE;
                    end
                    if (wipe_ptr == 17'h0FFFF) begin
                        state <= ST_DONE;
                        if (wipe_opt) begin
                            option_byte <= pend_opt;
                        end
                    end
                    wipe_ptr <= wipe_ptr + 17'h00001;
                end
                ST_DONE: begin
                    // busy drops with done, so the next request waits for idle
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fsap_access

// *** sim/fsap_tool_model.sv ***
`timescale 1ns/10ps
// ****************************************
// programming tool model
// ****************************************
module fsap_tool_model (
    output reg link_clk,
    output reg tool_oe,
    output reg tool_out,
    output reg attached,
    output reg vsel
);
    initial begin
        link_clk = 1'b0;
        tool_oe  = 1'b0;
        tool_out = 1'b0;
        attached = 1'b0;
        vsel     = 1'b0;
    end
    // session mode is entered before any frame is sent
    task session(input bit on);
        attached = on;
        vsel     = on;
    endtask
    // clock stands low between frames; data released to the pull-up after
    task frame(input [7:0] bits, input int half);
        tool_oe = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            tool_out = bits[i];
            #(half) link_clk = 1'b1;
            #(half) link_clk = 1'b0;
        end
        tool_oe = 1'b0;
        #(half);
    endtask
endmodule // fsap_tool_model

// *** sim/fsap_access_chk.sv ***
`timescale 1ns/10ps
`include "fsap_defines.vh"
// ****************************************
// port checker
// ****************************************
module fsap_access_chk (
    input wire        ref_clk,
    input wire        arst_n,
    input wire        tool_attached,
    input wire        incirc_serial_clock,
    input wire        link_clock_rise,
    input wire        app_pin_in,
    input wire        req_valid,
    input wire [1:0]  req_op,
    input wire [15:0] req_addr,
    input wire        req_external,
    input wire        busy,
    input wire        done,
    input wire [1:0]  result,
    input wire [7:0]  rd_data,
    input wire [7:0]  option_byte,
    input wire        readout_protect_option,
    input wire        low_voltage_detector_en,
    input wire [1:0]  mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire take = req_valid && !busy;
    wire prot = readout_protect_option && option_byte[0];
    property p_lvd_off;
        low_voltage_detector_en == !readout_protect_option;
    endproperty
    a_lvd_off: assert property (p_lvd_off) else $error("detector on under protection");
    property p_prot_bit;
        1'b1 |=> readout_protect_option == $past(option_byte[0]);
    endproperty
    a_prot_bit: assert property (p_prot_bit) else $error("protect flag not from option");
    property p_prog_done;
        take && req_op == `FSAP_OP_PROG |=> done && !busy;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("byte program not one cycle");
    property p_sec0_iap;
        take && mode == `FSAP_MODE_INAPP && req_op != `FSAP_OP_OPT_PROG && req_addr[15:12] == 4'hF
            |=> done && result == `FSAP_RES_PROTECTED;
    endproperty
    a_sec0_iap: assert property (p_sec0_iap) else $error("sector 0 touched");
    property p_prot_write;
        take && prot && req_op == `FSAP_OP_PROG |=> result == `FSAP_RES_PROTECTED;
    endproperty
    a_prot_write: assert property (p_prot_write) else $error("write under protection");
    property p_prot_read;
        !req_valid && !busy && req_external && prot |=> rd_data == 8'h00;
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("protected data read out");
    property p_pin_held;
        tool_attached [*6] |-> app_pin_in == 1'b0;
    endproperty
    a_pin_held: assert property (p_pin_held) else $error("pin given to application");
    property p_link_edge;
        $rose(incirc_serial_clock) |-> ##[2:6] link_clock_rise;
    endproperty
    a_link_edge: assert property (p_link_edge) else $error("link clock edge missed");
    property p_pulse;
        link_clock_rise |=> !link_clock_rise;
    endproperty
    a_pulse: assert property (p_pulse) else $error("edge pulse too long");
    property p_busy_end;
        $fell(busy) |-> done;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("erase ended without done");
endmodule // fsap_access_chk
bind fsap_access fsap_access_chk u_chk (.ref_clk, .arst_n, .tool_attached, .incirc_serial_clock,
    .link_clock_rise, .app_pin_in, .req_valid, .req_op, .req_addr, .req_external, .busy, .done,
    .result, .rd_data, .option_byte, .readout_protect_option, .low_voltage_detector_en, .mode);

// *** sim/fsap_access_tb_top.sv ***
`timescale 1ns/10ps
`include "fsap_defines.vh"
// ****************************************
// testbench
// ****************************************
module fsap_access_tb_top;
    reg        ref_clk = 1'b0;
    reg        arst_n = 1'b0;
    reg        tool_socket = 1'b0;
    reg        link_data_out = 1'b0;
    reg        link_data_oe = 1'b0;
    reg        app_pin_out = 1'b0;
    reg        app_pin_oe = 1'b0;
    reg        iap_enter = 1'b0;
    reg        fetch_from_sector0 = 1'b0;
    reg        req_valid = 1'b0;
    reg [1:0]  req_op = 2'h0;
    reg [15:0] req_addr = 16'h0000;
    reg [7:0]  req_data = 8'h00;
    reg        req_external = 1'b0;
    reg [1:0]  cur_mode = 2'h0;
    reg        prot = 1'b0;
    reg [7:0]  shadow [0:8191];
    wire       attached, vsel, link_clk, tool_oe, tool_out, dout, doe, sdata, rise, ldata, app_in;
    wire       busy, done, rpo, low_voltage_detector;
    wire [1:0] result, mode;
    wire [7:0] rd_data, option_byte;
    int        failures = 0;
    int        cmp_count = 0;
    int        pulses = 0;
    int        i;
    // released wire floats to the pull-up
    assign sdata = doe ? dout : (tool_oe ? tool_out : 1'b1);
    fsap_tool_model tool (.link_clk(link_clk), .tool_oe(tool_oe), .tool_out(tool_out),
        .attached(attached), .vsel(vsel));
    // short array keeps each erase walk near 8K cycles
    fsap_access #(.ARRAY_BYTES(17'h02000)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .tool_socket(tool_socket), .tool_attached(attached), .programming_voltage_select(vsel),
        .incirc_serial_clock(link_clk), .incirc_serial_data_in(sdata),
        .incirc_serial_data_out(dout), .incirc_serial_data_oe(doe),
        .link_data_out(link_data_out), .link_data_oe(link_data_oe), .link_clock_rise(rise),
        .link_data(ldata), .app_pin_out(app_pin_out), .app_pin_oe(app_pin_oe),
        .app_pin_in(app_in), .iap_enter(iap_enter), .fetch_from_sector0(fetch_from_sector0),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_external(req_external), .busy(busy), .done(done), .result(result),
        .rd_data(rd_data), .option_byte(option_byte), .readout_protect_option(rpo),
        .low_voltage_detector_en(low_voltage_detector), .mode(mode));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rise === 1'b1) pulses <= pulses + 1;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function logic [1:0] exp_res(input logic [1:0] op, input logic [15:0] a);
        logic wr;
        wr = (op == `FSAP_OP_PROG) || (op == `FSAP_OP_SEC_ERASE);
        if (!wr && (cur_mode == `FSAP_MODE_APP || cur_mode == `FSAP_MODE_INAPP))
            return `FSAP_RES_PROTECTED;
        if (wr && a < 16'hE000) return `FSAP_RES_RANGE;
        if (wr && (prot || (cur_mode == `FSAP_MODE_INAPP && a >= `FSAP_SEC0_BASE)))
            return `FSAP_RES_PROTECTED;
        return `FSAP_RES_OK;
    endfunction
    task wipe;
        for (int k = 0; k < 8192; k++) shadow[k] = `FSAP_ERASED_BYTE;
    endtask
    task req(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
        logic [1:0] r;
        int k;
        r = exp_res(op, a);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_data = d;
        tick(1);
        req_valid = 1'b0;
        for (k = 0; k < 9000 && done !== 1'b1; k++) tick(1);
        if (k == 9000) begin
            failures++;
            give_verdict;
        end
        check({6'h00, result}, {6'h00, r});
        if (r == `FSAP_RES_OK) case (op)
            `FSAP_OP_PROG: shadow[a[12:0]] = shadow[a[12:0]] & d;
            `FSAP_OP_SEC_ERASE: for (k = 0; k < 4096; k++) shadow[{a[12], k[11:0]}] = 8'hFF;
            `FSAP_OP_MASS_ERASE: wipe;
            default: begin
                if (prot && !d[0]) wipe;
                prot = d[0];
            end
        endcase
        tick(1);
    endtask
    task rd(input logic [15:0] a, input logic ext);
        req_addr = a;
        req_external = ext;
        tick(2);
        check(rd_data, (ext && prot) ? 8'h00 : shadow[a[12:0]]);
        req_external = 1'b0;
        tick(1);
    endtask
    task set_mode(input logic [1:0] m);
        cur_mode = m;
        tool_socket = (m == `FSAP_MODE_TOOL);
        tool.session(m == `FSAP_MODE_CIRCUIT);
        iap_enter = (m == `FSAP_MODE_INAPP);
        fetch_from_sector0 = iap_enter;
        tick(8);
        check({6'h00, mode}, {6'h00, m});
    endtask
    initial begin
        void'($urandom(3));
        tick(16);
        arst_n = 1'b1; // no reset from the bench once a session may run
        tick(6);
        check({4'h0, low_voltage_detector, busy, done, rpo}, 8'h08);
        check(option_byte, `FSAP_OPT_RESET);
        set_mode(`FSAP_MODE_TOOL);
        req(`FSAP_OP_MASS_ERASE, 16'hE000, 8'h00);
        for (i = 0; i < 24; i++) begin
            req_data = 8'($urandom);
            req(`FSAP_OP_PROG, 16'hE000 | 16'($urandom_range(0, 8191)), req_data);
            rd(req_addr, 1'b0);
        end
        req(`FSAP_OP_PROG, 16'hDFFF, 8'h00);
        req(`FSAP_OP_PROG, 16'hEFFF, 8'h5A);
        req(`FSAP_OP_SEC_ERASE, 16'hE123, 8'h00);
        for (i = 0; i < 8; i++) rd(16'hE000 | 16'(i * 1021), 1'b0);
        set_mode(`FSAP_MODE_INAPP);
        req(`FSAP_OP_PROG, 16'hF010, 8'h00);
        req(`FSAP_OP_SEC_ERASE, 16'hFF00, 8'h00);
        req(`FSAP_OP_MASS_ERASE, 16'hE000, 8'h00);
        req(`FSAP_OP_PROG, 16'hE010, 8'h0F);
        rd(16'hF010, 1'b0);
        set_mode(`FSAP_MODE_APP);
        req(`FSAP_OP_OPT_PROG, 16'h0000, 8'h01);
        set_mode(`FSAP_MODE_CIRCUIT);
        app_pin_oe = 1'b1;
        app_pin_out = 1'($urandom);
        pulses = 0;
        tool.frame(8'($urandom), 400);
        tool.frame(8'hA5, 400);
        tick(8);
        check(8'(pulses), 8'h10);
        check({6'h00, app_in, ldata}, 8'h01);
        link_data_oe = 1'b1;
        tick(3);
        check({6'h00, doe, sdata}, 8'h02);
        link_data_oe = 1'b0;
        req(`FSAP_OP_OPT_PROG, 16'h0000, 8'h01);
        tick(2);
        check({6'h00, rpo, low_voltage_detector}, 8'h02);
        req(`FSAP_OP_PROG, 16'hE020, 8'h00);
        rd(16'hE020, 1'b1);
        req(`FSAP_OP_OPT_PROG, 16'h0000, 8'h00);
        tick(2);
        check(option_byte, 8'h00);
        for (i = 0; i < 8; i++) rd(16'hE000 | 16'(i * 1021), 1'b1);
        give_verdict;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        give_verdict;
    end
endmodule // fsap_access_tb_top
